// ===== rtl/eeprom_ctrl_pkg.sv
// Purpose : Shared constants and types for the data EEPROM program control.
// Assumes : APB slave with 32-bit data and 12-bit byte addresses.
// Notes   : Window bytes sit one per aligned word in the low byte lane.
package eeprom_ctrl_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W        = 12;
	localparam logic [11:0] CTRL_OFFSET   = 12'h02C;
	localparam logic [11:0] STATUS_OFFSET = 12'h030;
	localparam logic [2:0]  WINDOW_TAG    = 3'h2;
	localparam int unsigned WIN_TAG_LSB   = 9;
	localparam int unsigned MEM_BYTES     = 128;
	localparam int unsigned MEM_IDX_W     = 7;
	localparam int unsigned LATCH_NUM     = 4;
	localparam int unsigned LATCH_SEL_W   = 2;
	localparam int unsigned ROW_W         = MEM_IDX_W - LATCH_SEL_W;

	// ------------------------------------------------------------------
	// Control register fields and reset values
	// ------------------------------------------------------------------
	localparam int unsigned PGM_BIT     = 0;
	localparam int unsigned LAT_BIT     = 1;
	localparam int unsigned IRQ_EN_BIT  = 2;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_LP_BIT   = 1;
	localparam int unsigned ST_IRQ_BIT  = 2;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;

	// ------------------------------------------------------------------
	// Timing defaults, in system clock cycles
	// ------------------------------------------------------------------
	localparam int unsigned CNT_W               = 16;
	localparam int unsigned ERASE_CYCLES_RESET  = 2000;
	localparam int unsigned PROG_CYCLES_RESET   = 2000;

	typedef struct packed {
		logic completion_irq_enable;
		logic write_latch_mode;
		logic program_start;
	} ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG  = 3'b100
	} prog_state_t;

endpackage : eeprom_ctrl_pkg

// ===== rtl/data_eeprom_program_control.sv
// Purpose : Data EEPROM read window, row latches and program sequencer.
// Assumes : Synchronous inputs on pclk; halt and wait requests are levels.
// Notes   : Cell array is modelled in flip-flops, erased state all ones.
//
// Notes on behaviour
// - Reset or halt stops erase or programming at once; halt means low power.
// - Wait lets a running cycle finish before low power is entered.
// - With latch mode clear, window reads return the stored byte.
// - Latch mode set, start clear: window writes load the addressed latch.
// - Number of row latches is a design constant.
// - Programmed row comes from the high address of the last latched write.
// - Setting start runs erase then program on written latches only.
// - At cycle end start, latch mode and all latches clear together.
// - Cycle end raises the interrupt only when its enable is set.
// - Pending interrupt clears when the vector fetch is acknowledged.
// - Latch mode sets any time except in the cycle end clock; software clear works only with start clear.
// - A second write to a loaded latch ANDs with its old value.
// - Latches clear when latch mode is set, when it falls, and at end.
// - Latched data is never readable; window reads in latch mode drive nothing.
// - Window writes with latch mode clear are ignored.
// - Control upper five bits read zero; low three reset to zero.
// - Erase and program chain automatically under an internal timer.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module data_eeprom_program_control
	import eeprom_ctrl_pkg::*;
#(
	parameter logic [15:0] ERASE_CYCLES = 16'(eeprom_ctrl_pkg::ERASE_CYCLES_RESET),
	parameter logic [15:0] PROG_CYCLES  = 16'(eeprom_ctrl_pkg::PROG_CYCLES_RESET)
) (
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [eeprom_ctrl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                        pwdata,
	input  wire logic [3:0]                         pstrb,
	output var  logic [31:0]                        prdata,
	output var  logic                               pready,
	output var  logic                               pslverr,
	input  wire logic                               halt_req,
	input  wire logic                               wait_req,
	input  wire logic                               irq_ack,
	output var  logic                               irq,
	output var  logic                               low_power,
	output var  logic                               read_drive
);

	// ------------------------------------------------------------------
	// Address decode helpers
	// ------------------------------------------------------------------
	// Window bytes sit one per word; an unaligned address is refused.
	function automatic logic win_hit(input logic [ADDR_W-1:0] a);
		win_hit = (a[ADDR_W-1:WIN_TAG_LSB] == WINDOW_TAG) && (a[1:0] == 2'h0);
	endfunction : win_hit

	function automatic logic [MEM_IDX_W-1:0] win_idx(
		input logic [ADDR_W-1:0] a);
		win_idx = a[MEM_IDX_W+1:2];
	endfunction : win_idx

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]             mem_reg   [MEM_BYTES];
	logic [7:0]             latch_reg [LATCH_NUM];
	logic [LATCH_NUM-1:0]   loaded_reg;
	logic [ROW_W-1:0]       row_reg;
	ctrl_t                  ctrl_reg;
	ctrl_t                  ctrl_next;
	prog_state_t            state_reg;
	logic [CNT_W-1:0]       cnt_reg;
	logic                   pready_reg;
	logic [31:0]            prdata_reg;
	logic                   pslverr_reg;
	logic                   irq_reg;
	logic                   low_power_reg;
	logic                   read_drive_reg;

	logic                   setup;
	logic                   access;
	logic                   bus_wr;
	logic                   ctrl_wr;
	logic                   win_wr;
	logic                   cycle_done;
	logic                   cycle_abort;
	logic                   latch_clr;
	logic                   busy;
	logic [31:0]            rdata_next;
	logic                   rerr_next;
	logic                   rdrive_next;
	logic [LATCH_SEL_W-1:0] wsel;
	logic [MEM_IDX_W-1:0]   widx;

	assign setup   = psel && !penable && !pready_reg;
	assign access  = psel && penable && pready_reg;
	assign bus_wr  = access && pwrite && pstrb[0];
	assign ctrl_wr = bus_wr && (paddr == CTRL_OFFSET);
	assign win_wr  = bus_wr && win_hit(paddr);
	// The window index is a net so that its row and latch fields can be
	// sliced apart.
	assign widx    = win_idx(paddr);
	assign wsel    = widx[LATCH_SEL_W-1:0];
	assign busy    = (state_reg != ST_IDLE);

	// Ending and aborting are exclusive: halt always takes precedence.
	assign cycle_done  = (state_reg == ST_PROG) && (cnt_reg == '0) &&
		ctrl_reg.program_start && !halt_req;
	assign cycle_abort = busy && (halt_req || !ctrl_reg.program_start);

	// ------------------------------------------------------------------
	// Control register next value
	// ------------------------------------------------------------------
	// Hardware clears at cycle end override a software write in the same
	// cycle, so a late set of latch mode is lost; software should wait
	// for the sequencer to go idle before touching this register.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr) begin
			ctrl_next.completion_irq_enable = pwdata[IRQ_EN_BIT];
			if (pwdata[LAT_BIT]) begin
				ctrl_next.write_latch_mode = 1'b1;
			end else if (!ctrl_reg.program_start) begin
				ctrl_next.write_latch_mode = 1'b0;
			end
			// A start without latch mode would program nothing useful.
			if (pwdata[PGM_BIT]) begin
				ctrl_next.program_start = ctrl_next.write_latch_mode;
			end else begin
				ctrl_next.program_start = 1'b0;
			end
		end
		if (cycle_done) begin
			ctrl_next.program_start    = 1'b0;
			ctrl_next.write_latch_mode = 1'b0;
		end
		// Halt clears start but keeps latch mode and the latches, so
		// software may restart the same row after waking.
		if (halt_req) begin
			ctrl_next.program_start = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= ctrl_t'(CTRL_RESET[2:0]);
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Latch mode edges in either direction wipe the latches.
	assign latch_clr = cycle_done ||
		(ctrl_next.write_latch_mode != ctrl_reg.write_latch_mode);

	// ------------------------------------------------------------------
	// Row latches
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Latches idle at all ones, so the AND merge leaves a first
			// write to a latch unchanged.
			for (int i = 0; i < LATCH_NUM; i++) begin
				latch_reg[i] <= ERASED_BYTE;
			end
			loaded_reg <= '0;
			row_reg    <= '0;
		end else if (latch_clr) begin
			for (int i = 0; i < LATCH_NUM; i++) begin
				latch_reg[i] <= ERASED_BYTE;
			end
			loaded_reg <= '0;
		end else if (win_wr && ctrl_reg.write_latch_mode &&
			!ctrl_reg.program_start) begin
			latch_reg[wsel]  <= latch_reg[wsel] & pwdata[7:0];
			loaded_reg[wsel] <= 1'b1;
			row_reg <= widx[MEM_IDX_W-1:LATCH_SEL_W];
		end
	end

	// ------------------------------------------------------------------
	// Erase and program sequencer
	// ------------------------------------------------------------------
	// The timer decides cycle length unless a halt or a software clear of start aborts it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else if (cycle_abort) begin
			// A software clear of start in mid-cycle lands here as well and
			// may leave the row partly erased; only a new cycle repairs it.
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// A halt that meets the start must not let the sequencer
					// leave idle for one stray cycle.
					if (ctrl_reg.program_start && !halt_req) begin
						state_reg <= ST_ERASE;
						// The load edge is the first counted cycle.
						cnt_reg   <= ERASE_CYCLES - 16'h0001;
					end
				end
				ST_ERASE: begin
					if (cnt_reg == '0) begin
						state_reg <= ST_PROG;
						cnt_reg   <= PROG_CYCLES - 16'h0001;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				ST_PROG: begin
					if (cnt_reg == '0) begin
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Cell array
	// ------------------------------------------------------------------
	// Only loaded latches touch the array, so untouched bytes of the
	// row keep their contents. Erase lands at the end of the erase
	// phase, so an abort before it leaves the cells as they were.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int j = 0; j < MEM_BYTES; j++) begin
				mem_reg[j] <= ERASED_BYTE;
			end
		end else if (!cycle_abort) begin
			for (int i = 0; i < LATCH_NUM; i++) begin
				if (loaded_reg[i] && (cnt_reg == '0)) begin
					if (state_reg == ST_ERASE) begin
						mem_reg[{row_reg, LATCH_SEL_W'(i)}] <= ERASED_BYTE;
					end else if (state_reg == ST_PROG) begin
						mem_reg[{row_reg, LATCH_SEL_W'(i)}] <=
							latch_reg[i];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Read data is decoded in the setup cycle and registered, so the
	// access cycle shows state as it stood one edge earlier. A status
	// read may therefore lag the end of a cycle by one clock.
	always_comb begin
		rdata_next  = 32'h0000_0000;
		rerr_next   = 1'b0;
		rdrive_next = 1'b0;
		if (paddr == CTRL_OFFSET) begin
			rdata_next[2:0] = ctrl_reg;
			rdrive_next     = !pwrite;
		end else if (paddr == STATUS_OFFSET) begin
			rdata_next[ST_BUSY_BIT] = busy;
			rdata_next[ST_LP_BIT]   = low_power_reg;
			rdata_next[ST_IRQ_BIT]  = irq_reg;
			rdrive_next             = !pwrite;
		end else if (win_hit(paddr)) begin
			if (!ctrl_reg.write_latch_mode) begin
				rdata_next[7:0] = mem_reg[win_idx(paddr)];
				rdrive_next     = !pwrite;
			end
			// In latch mode the read returns zero and flags no drive.
		end else begin
			rerr_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg     <= 1'b0;
			prdata_reg     <= 32'h0000_0000;
			pslverr_reg    <= 1'b0;
			read_drive_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				prdata_reg     <= pwrite ? 32'h0000_0000 : rdata_next;
				pslverr_reg    <= rerr_next;
				read_drive_reg <= rdrive_next;
			end else begin
				prdata_reg     <= 32'h0000_0000;
				pslverr_reg    <= 1'b0;
				read_drive_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Completion interrupt and power state
	// ------------------------------------------------------------------
	// A fetch in the same cycle as a new completion loses to the set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else if (cycle_done && ctrl_reg.completion_irq_enable) begin
			irq_reg <= 1'b1;
		end else if (irq_ack) begin
			irq_reg <= 1'b0;
		end
	end

	// Wait only takes effect once the sequencer is idle.
	// Halt wins over wait and is followed with one edge of delay.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_reg <= 1'b0;
		end else begin
			low_power_reg <= halt_req || (wait_req && !busy &&
				!ctrl_reg.program_start);
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;
	assign irq        = irq_reg;
	assign low_power  = low_power_reg;
	assign read_drive = read_drive_reg;

endmodule : data_eeprom_program_control

`default_nettype wire

// ===== test/data_eeprom_program_control_properties.sv
// Purpose : Port-level properties of the data EEPROM program control.
// Assumes : One pclk domain, asynchronous active-low presetn.
// Notes   : Bound onto every instance of the design.
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_program_control_properties
	import eeprom_ctrl_pkg::*;
#(
	parameter logic [15:0] ERASE_CYCLES = 16'h0004,
	parameter logic [15:0] PROG_CYCLES  = 16'h0004
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              halt_req,
	input wire logic              wait_req,
	input wire logic              irq_ack,
	input wire logic              irq,
	input wire logic              low_power,
	input wire logic              read_drive
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("access cycle not answered once");
	property p_drive;
		read_drive |-> pready && !pwrite;
	endproperty
	a_drive: assert property (p_drive)
		else $error("data driven outside a read");
	property p_undriven;
		pready && !pwrite && !read_drive |-> prdata == 32'h0;
	endproperty
	a_undriven: assert property (p_undriven)
		else $error("undriven read carries data");
	property p_ctrl_zero;
		pready && !pwrite && paddr == CTRL_OFFSET |-> prdata[31:3] == 29'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("control upper bits not zero");
	property p_refused;
		pslverr |-> pready && !read_drive;
	endproperty
	a_refused: assert property (p_refused)
		else $error("refused access drove data");
	property p_halt;
		halt_req |-> ##[1:2] low_power;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not reach low power");
	property p_irq_hold;
		irq && !irq_ack |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped without fetch");
	property p_irq_drop;
		$fell(irq) |-> $past(irq_ack);
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("interrupt fell with no fetch");
	property p_wake;
		!wait_req && !halt_req ##1 !wait_req && !halt_req |-> ##[0:2] !low_power;
	endproperty
	a_wake: assert property (p_wake)
		else $error("low power held with no request");
endmodule : data_eeprom_program_control_properties
bind data_eeprom_program_control data_eeprom_program_control_properties #(
	.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .halt_req(halt_req), .wait_req(wait_req),
	.irq_ack(irq_ack), .irq(irq), .low_power(low_power),
	.read_drive(read_drive));
`default_nettype wire

// ===== test/core_irq_model.sv
// Purpose : Interrupt controller side that fetches the completion vector.
// Assumes : Vector fetch is a one-cycle acknowledge pulse.
// Notes   : A slow setting delays the fetch, as a busy core would.
`timescale 1ns/10ps
`default_nettype none
module core_irq_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic irq,
	input  wire logic slow,
	output var  logic irq_ack
);
	logic [3:0] wait_cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_reg <= 4'h0;
			irq_ack <= 1'b0;
		end else if (irq && !irq_ack && wait_cnt_reg == (slow ? 4'h6 : 4'h1)) begin
			irq_ack <= 1'b1;
			wait_cnt_reg <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			wait_cnt_reg <= (irq && !irq_ack) ? wait_cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule : core_irq_model
`default_nettype wire

// ===== test/data_eeprom_program_control_bench.sv
// Purpose : Self-checking bench for the data EEPROM program control.
// Assumes : Short erase and program counts keep the run brief.
// Notes   : Software-side rules are kept by the stimulus order.
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_program_control_bench;
	import eeprom_ctrl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        halt_req, wait_req, irq_ack, irq, low_power, read_drive;
	logic        slow, rerr, rdrv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	int          err_count, samples_checked, irq_hits;
	data_eeprom_program_control #(.ERASE_CYCLES(16'h0008),
		.PROG_CYCLES(16'h0008)) data_eeprom_program_control_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_req(halt_req), .wait_req(wait_req), .irq_ack(irq_ack),
		.irq(irq), .low_power(low_power), .read_drive(read_drive));
	core_irq_model core_irq_model_i (.pclk(pclk), .presetn(presetn),
		.irq(irq), .slow(slow), .irq_ack(irq_ack));
	always #50 pclk = ~pclk;
	always @(posedge pclk) if (irq === 1'b1 && irq_ack === 1'b1) irq_hits++;
	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	function automatic logic [11:0] win(input int i);
		return 12'h400 + 12'(4 * i);
	endfunction : win
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) chk(32'h1, 32'h0);
		rdat = prdata;
		rerr = pslverr;
		rdrv = read_drive;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat, e);
	endtask : rd
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, STATUS_OFFSET, 8'h00);
			n++;
		end while (rdat[ST_BUSY_BIT] !== 1'b0 && n < 40);
		if (n >= 40) chk(32'h1, 32'h0);
	endtask : wait_idle
	initial begin
		#300000;
		err_count++;
		conclude();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, halt_req, wait_req, slow} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 8'hF8);
		rd(CTRL_OFFSET, 32'h0);
		rd(win(5), 32'hFF);
		chk({31'h0, rdrv}, 32'h1);
		wr(win(5), 8'h00);
		rd(win(5), 32'hFF);
		// Partial row with a merged second write; latches stay hidden.
		wr(CTRL_OFFSET, 8'h02);
		wr(win(4), 8'h12);
		wr(win(5), 8'h34);
		wr(win(6), 8'hF0);
		wr(win(6), 8'h3C);
		rd(win(4), 32'h0);
		chk({31'h0, rdrv}, 32'h0);
		wr(CTRL_OFFSET, 8'h07);
		wr(CTRL_OFFSET, 8'h05);
		rd(CTRL_OFFSET, 32'h7);
		wait_idle();
		rd(CTRL_OFFSET, 32'h4);
		chk(32'(irq_hits), 32'h1);
		rd(win(4), 32'h12);
		rd(win(5), 32'h34);
		rd(win(6), 32'h30);
		rd(win(7), 32'hFF);
		// A latch loaded before latch mode fell must be forgotten.
		wr(CTRL_OFFSET, 8'h02);
		wr(win(8), 8'h00);
		wr(CTRL_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h02);
		wr(win(9), 8'h55);
		wr(CTRL_OFFSET, 8'h03);
		wait_idle();
		rd(win(8), 32'hFF);
		rd(win(9), 32'h55);
		chk(32'(irq_hits), 32'h1);
		slow <= 1'b1;
		wr(CTRL_OFFSET, 8'h06);
		wr(win(12), 8'h00);
		wr(CTRL_OFFSET, 8'h07);
		halt_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, low_power}, 32'h1);
		halt_req <= 1'b0;
		rd(CTRL_OFFSET, 32'h6);
		wr(CTRL_OFFSET, 8'h04);
		repeat (20) @(posedge pclk);
		chk(32'(irq_hits), 32'h1);
		wr(CTRL_OFFSET, 8'h06);
		wr(win(16), 8'hA5);
		wr(CTRL_OFFSET, 8'h07);
		wait_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, low_power}, 32'h0);
		wait_idle();
		repeat (2) @(posedge pclk);
		chk({31'h0, low_power}, 32'h1);
		wait_req <= 1'b0;
		rd(win(16), 32'hA5);
		repeat (10) @(posedge pclk);
		chk(32'(irq_hits), 32'h2);
		// A write without its low byte strobe must leave control alone.
		pstrb <= 4'h0;
		wr(CTRL_OFFSET, 8'h00);
		pstrb <= 4'hF;
		rd(CTRL_OFFSET, 32'h4);
		rd(12'h100, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		conclude();
	end
endmodule : data_eeprom_program_control_bench
`default_nettype wire
